// *** sim/pemux_pads.sv ***
// Pad model for the port E pins: resolves the block's drive against an external source.
// Assumes one external driver per pin, enabled only while the block is not driving.
`timescale 1ns/1ns

module pemux_pads (
	input  wire logic                     ref_clk,
	input  wire pemux_pkg::pemux_pins_s   pins,
	input  wire logic                     pullup_on,
	input  wire logic [3:0]               ext_val,
	input  wire logic [3:0]               ext_en,
	output logic      [3:0]               pin_in
);
	logic tog_q = 1'b0;

	// A floating pad keeps changing, so a stale level is never read as valid
	always @(posedge ref_clk) begin
		tog_q <= ~tog_q;
	end

	always_comb begin
		for (int i = 0; i < 3; i++) begin
			pin_in[i] = pins.oe[i] ? pins.out[i] : (ext_en[i] ? ext_val[i] : tog_q);
		end
		pin_in[3] = ext_en[3] ? ext_val[3] : (pullup_on ? 1'b1 : tog_q);
	end
endmodule

// *** sim/pemux_port_e_tb.sv ***
// Self-checking bench for the port E pin control block.
// Assumes the register offsets and chosen reset values of the constants header.
`timescale 1ns/1ns
`include "pemux_cfg.svh"

module pemux_port_e_tb;
	logic                       ref_clk, rst, reg_wr, reg_rd, hv, mc_n, cap3, cap5, pu, route, gpd_n;
	logic [3:0]                 addr, ext_val, ext_en, pin_in;
	logic [7:0]                 wdata, rdata;
	logic [4:0]                 slew;
	pemux_pkg::pemux_periph_s   periph;
	pemux_pkg::pemux_pins_s     pins;
	int                         n_errors, compares;

	pemux_port_e i_dut (.ref_clk(ref_clk), .rst(rst), .reg_addr(addr), .reg_wdata(wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata), .periph(periph),
		.hv_prog_mode(hv), .pin_in(pin_in), .pins(pins), .slew_reduced(slew),
		.input_pin_pullup_on(pu), .master_clear_n(mc_n), .capcmp3_capture_in(cap3),
		.capcmp5_capture_in(cap5), .unit3_pin_route_cfg(route), .global_pullup_disable_n(gpd_n));
	pemux_pads i_pads (.ref_clk(ref_clk), .pins(pins), .pullup_on(pu), .ext_val(ext_val),
		.ext_en(ext_en), .pin_in(pin_in));

	task chk(input logic [7:0] g, input logic [7:0] e, input string m);
		compares++;
		if (g !== e) begin
			n_errors++;
			$display("Error at %0t: %s got %h expected %h", $time, m, g, e);
		end
	endtask
	task wr(input logic [3:0] a, input logic [7:0] d);
		addr <= a;
		wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		@(posedge ref_clk);
	endtask
	task rc(input logic [3:0] a, input logic [7:0] e, input string m, input logic [7:0] mk = 8'hff);
		addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 chk(rdata & mk, e, m);
		@(posedge ref_clk);
	endtask
	task settle(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task pchk(input logic [2:0] oe, input logic [2:0] out, input string m);
		chk({2'h0, pins.oe, pins.out}, {2'h0, oe, out}, m);
	endtask
	task pu_is(input logic e);
		settle(2);
		chk({7'h0, pu}, {7'h0, e}, "pull-up");
	endtask

	task t_reset;
		chk({3'h0, slew}, 8'h1f, "slew reset");
		chk({5'h0, pins.oe}, 8'h00, "oe reset");
		rc(`PEMUX_OFF_DIR, 8'h87, "dir reset");
		rc(`PEMUX_OFF_ANSEL, 8'h07, "analog reset");
		rc(`PEMUX_OFF_CFG3H, `PEMUX_CFG3H_RST, "cfg3h reset");
		rc(`PEMUX_OFF_CFG4L, `PEMUX_CFG4L_RST, "cfg4l reset");
		chk({7'h0, pu}, 8'h01, "pull-up reset");
	endtask
	task t_unimpl;
		wr(`PEMUX_OFF_LATCH, 8'hff);
		rc(`PEMUX_OFF_LATCH, 8'h07, "latch bits");
		wr(4'h8, 8'hff);
		rc(4'h8, 8'h00, "unmapped");
		wr(`PEMUX_OFF_SLEW, 8'h00);
		rc(`PEMUX_OFF_SLEW, 8'h00, "slew write");
		chk({3'h0, slew}, 8'h00, "slew standard");
	endtask
	task t_lvp;
		wr(`PEMUX_OFF_CFG4L, 8'h00);
		rc(`PEMUX_OFF_CFG4L, 8'h04, "lvp locked");
		hv <= 1'b1;
		wr(`PEMUX_OFF_CFG4L, 8'h00);
		hv <= 1'b0;
		rc(`PEMUX_OFF_CFG4L, 8'h00, "lvp in hv mode");
	endtask
	task t_latch;
		wr(`PEMUX_OFF_ANSEL, 8'h00);
		wr(`PEMUX_OFF_DIR, 8'h80);
		wr(`PEMUX_OFF_DATA, 8'h05);
		settle(2);
		pchk(3'h7, 3'h5, "latch drive");
		rc(`PEMUX_OFF_DATA, 8'h05, "pin read", 8'h07);
		wr(`PEMUX_OFF_ANSEL, 8'h07);
		settle(2);
		pchk(3'h7, 3'h5, "analog drive");
		rc(`PEMUX_OFF_DATA, 8'h00, "analog read", 8'h07);
	endtask
	task t_input;
		wr(`PEMUX_OFF_DIR, 8'h87);
		wr(`PEMUX_OFF_ANSEL, 8'h00);
		wr(`PEMUX_OFF_CFG3H, 8'hbb);
		ext_val <= 4'h5;
		ext_en <= 4'hf;
		settle(3);
		chk({5'h0, pins.oe}, 8'h00, "input oe");
		rc(`PEMUX_OFF_DATA, 8'h05, "input read", 8'h07);
		chk({6'h0, cap5, cap3}, 8'h03, "capture");
		chk({7'h0, mc_n}, 8'h00, "master clear low");
		wr(`PEMUX_OFF_CFG3H, 8'h3b);
		ext_val <= 4'hd;
		settle(3);
		chk({7'h0, mc_n}, 8'h01, "master clear off");
		rc(`PEMUX_OFF_DATA, 8'h0d, "input only bit");
		wr(`PEMUX_OFF_ANSEL, 8'h07);
		settle(3);
		rc(`PEMUX_OFF_DATA, 8'h08, "input cut", 8'h0f);
	endtask
	task t_prio;
		ext_en <= 4'h0;
		wr(`PEMUX_OFF_DIR, 8'h80);
		wr(`PEMUX_OFF_CFG3H, 8'hbb);
		periph <= 8'h7d;
		settle(2);
		pchk(3'h7, 3'h2, "all sources");
		periph <= 8'h3d;
		settle(2);
		pchk(3'h7, 3'h3, "compare 3");
		periph <= 8'h35;
		settle(2);
		pchk(3'h7, 3'h2, "routed here");
		wr(`PEMUX_OFF_CFG3H, 8'hbf);
		settle(2);
		pchk(3'h7, 3'h3, "routed away");
		chk({7'h0, route}, 8'h01, "route bit");
		periph <= 8'h00;
		settle(2);
		pchk(3'h7, 3'h5, "latch only");
	endtask
	task t_pullup;
		pu_is(1'b1);
		wr(`PEMUX_OFF_CFG3H, 8'h3f);
		pu_is(1'b0);
		wr(`PEMUX_OFF_INTERRUPT_CONTROL_TWO, 8'h75);
		pu_is(1'b1);
		chk({7'h0, gpd_n}, 8'h00, "global pull-up bit");
		wr(`PEMUX_OFF_DIR, 8'h07);
		pu_is(1'b0);
		hv <= 1'b1;
		wr(`PEMUX_OFF_CFG4L, 8'h04);
		hv <= 1'b0;
		pu_is(1'b1);
	endtask

	task report_and_stop;
		$display("Checks %0d, errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	initial begin
		#200000;
		n_errors++;
		$display("Error at %0t: run timed out", $time);
		report_and_stop;
	end
	initial begin
		rst = 1'b1;
		{reg_wr, reg_rd, hv, addr, wdata, ext_val, ext_en} = '0;
		periph = '0;
		n_errors = 0;
		compares = 0;
		repeat (5) @(posedge ref_clk);
		rst <= 1'b0;
		settle(2);
		t_reset;
		t_unimpl;
		t_lvp;
		t_latch;
		t_input;
		t_prio;
		t_pullup;
		report_and_stop;
	end
endmodule

// *** src/pemux_cfg.svh ***
// Register offsets, field positions and reset values for the port E pin control block.
// Assumes a byte-wide register port with offsets chosen by this block.
`ifndef PEMUX_CFG_SVH
`define PEMUX_CFG_SVH

`define PEMUX_ADDR_W        4
`define PEMUX_OFF_DATA      4'h0
`define PEMUX_OFF_LATCH     4'h1
`define PEMUX_OFF_DIR       4'h2
`define PEMUX_OFF_ANSEL     4'h3
`define PEMUX_OFF_INTERRUPT_CONTROL_TWO   4'h4
`define PEMUX_OFF_SLEW      4'h5
`define PEMUX_OFF_CFG3H     4'h6
`define PEMUX_OFF_CFG4L     4'h7

`define PEMUX_DIR_MASK      8'h87
`define PEMUX_LAT_MASK      8'h07
`define PEMUX_ANS_MASK      8'h07
`define PEMUX_INTERRUPT_CONTROL_TWO_MASK  8'hf5
`define PEMUX_SLEW_MASK     8'h1f
`define PEMUX_CFG3H_MASK    8'hbf
`define PEMUX_CFG4L_MASK    8'hc5

`define PEMUX_DIR_RST       8'h87
`define PEMUX_ANS_RST       8'h07
`define PEMUX_LAT_RST       8'h00
`define PEMUX_INTERRUPT_CONTROL_TWO_RST   8'hf5
`define PEMUX_SLEW_RST      8'h1f
`define PEMUX_CFG3H_RST     8'hbf
`define PEMUX_CFG4L_RST     8'h85

`define PEMUX_WPU_BIT       7
`define PEMUX_GPU_BIT       7
`define PEMUX_PE_SLEW_SELECT_BIT      4
`define PEMUX_MASTER_CLEAR_ENABLE_CFG_BIT     7
`define PEMUX_ROUTE_BIT     2
`define PEMUX_LVP_BIT       2

`endif

// *** src/pemux_pkg.sv ***
// Types shared by the port E pin control block.
// Assumes the constants header is included by the design file.
package pemux_pkg;
	typedef struct packed {
		logic       epwm3_out_a;
		logic       epwm3_out_a_en;
		logic       epwm3_out_b;
		logic       epwm3_out_b_en;
		logic       capcmp3_out;
		logic       capcmp3_out_en;
		logic       capcmp5_out;
		logic       capcmp5_out_en;
	} pemux_periph_s;

	typedef struct packed {
		logic [2:0] out;
		logic [2:0] oe;
	} pemux_pins_s;
endpackage

// *** src/pemux_port_e.sv ***
// Port E pin control: latch, direction, analog select, peripheral output priority,
// input-only pin / master clear, pull-up and slew control, config bits.
// Assumes pins come from outside the clock domain; peripherals share ref_clk.
//
// Behaviour
// - Several enabled outputs on a pin: the highest-priority source drives it.
// - Digital outputs still drive the pin while it is in analog mode.
// - Direction 0, analog 0: pin driven from its output latch bit.
// - Direction 1: digital input through buffer, cut off by analog select.
// - Master clear enable 0: fourth pin is a digital input-only bit.
// - Master clear enable 1: fourth pin is an active-low reset input.
// - Bit 0: unit 3 compare drives with direction 0, captures with 1.
// - Bit 2: unit 5 compare drives with direction 0, captures with 1.
// - Bit 1 carries PWM channel 3 output B when direction 0.
// - PWM 3 A and unit 3 reach bit 0 only with route bit clear.
// - Analog select 1 disables input buffer, digital reads return 0.
// - Analog select never changes output drive.
// - Reset sets every analog select bit to 1.
// - Reset sets every direction bit to 1.
// - Per-port slew select, reduced rate after reset.
// - Low-voltage-programming bit writable only in high-voltage programming mode.
// - Unimplemented bits ignore writes and read 0.
// - Data register write updates latch, read returns pin levels.
// - Global pull-up disable 0 lets the input pin pull-up enable act.
// - Pull-up forced on under master clear or low-voltage programming.
//
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/1ns
`include "pemux_cfg.svh"

module pemux_port_e (
	input  wire logic                       ref_clk,
	input  wire logic                       rst,
	input  wire logic [`PEMUX_ADDR_W-1:0]   reg_addr,
	input  wire logic [7:0]                 reg_wdata,
	input  wire logic                       reg_wr,
	input  wire logic                       reg_rd,
	output logic      [7:0]                 reg_rdata,
	input  wire pemux_pkg::pemux_periph_s   periph,
	input  wire logic                       hv_prog_mode,
	input  wire logic [3:0]                 pin_in,
	output pemux_pkg::pemux_pins_s          pins,
	output logic      [4:0]                 slew_reduced,
	output logic                            input_pin_pullup_on,
	output logic                            master_clear_n,
	output logic                            capcmp3_capture_in,
	output logic                            capcmp5_capture_in,
	output logic                            unit3_pin_route_cfg,
	output logic                            global_pullup_disable_n
);
	logic [7:0] dir_q;
	logic [7:0] lat_q;
	logic [7:0] ans_q;
	logic [7:0] interrupt_control_two_q;
	logic [7:0] slew_q;
	logic [7:0] cfg3h_q;
	logic [7:0] cfg4l_q;
	logic [3:0] sync1_q;
	logic [3:0] sync2_q;
	logic [3:0] din;
	logic [2:0] out_d;
	logic [7:0] rdata_d;
	logic       master_clear_enable_cfg;
	logic       low_volt_prog_cfg;
	logic       route_here;

	function automatic logic [7:0] wr_mask(input logic [7:0] old, input logic [7:0] nw,
		input logic [7:0] m);
		wr_mask = (old & ~m) | (nw & m);
	endfunction

	assign master_clear_enable_cfg      = cfg3h_q[`PEMUX_MASTER_CLEAR_ENABLE_CFG_BIT];
	assign low_volt_prog_cfg        = cfg4l_q[`PEMUX_LVP_BIT];
	assign route_here = ~cfg3h_q[`PEMUX_ROUTE_BIT];

	// Registers
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			dir_q <= `PEMUX_DIR_RST;
		end else if (reg_wr && reg_addr == `PEMUX_OFF_DIR) begin
			dir_q <= wr_mask(dir_q, reg_wdata, `PEMUX_DIR_MASK);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			lat_q <= `PEMUX_LAT_RST;
		end else if (reg_wr && (reg_addr == `PEMUX_OFF_LATCH || reg_addr == `PEMUX_OFF_DATA)) begin
			lat_q <= wr_mask(lat_q, reg_wdata, `PEMUX_LAT_MASK);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ans_q <= `PEMUX_ANS_RST;
		end else if (reg_wr && reg_addr == `PEMUX_OFF_ANSEL) begin
			ans_q <= wr_mask(ans_q, reg_wdata, `PEMUX_ANS_MASK);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			interrupt_control_two_q <= `PEMUX_INTERRUPT_CONTROL_TWO_RST;
		end else if (reg_wr && reg_addr == `PEMUX_OFF_INTERRUPT_CONTROL_TWO) begin
			interrupt_control_two_q <= wr_mask(interrupt_control_two_q, reg_wdata, `PEMUX_INTERRUPT_CONTROL_TWO_MASK);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			slew_q <= `PEMUX_SLEW_RST;
		end else if (reg_wr && reg_addr == `PEMUX_OFF_SLEW) begin
			slew_q <= wr_mask(slew_q, reg_wdata, `PEMUX_SLEW_MASK);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cfg3h_q <= `PEMUX_CFG3H_RST;
		end else if (reg_wr && reg_addr == `PEMUX_OFF_CFG3H) begin
			cfg3h_q <= wr_mask(cfg3h_q, reg_wdata, `PEMUX_CFG3H_MASK);
		end
	end

	// Low-voltage-programming bit held unless in high-voltage programming
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cfg4l_q <= `PEMUX_CFG4L_RST;
		end else if (reg_wr && reg_addr == `PEMUX_OFF_CFG4L) begin
			cfg4l_q <= wr_mask(cfg4l_q, reg_wdata,
				hv_prog_mode ? `PEMUX_CFG4L_MASK : (`PEMUX_CFG4L_MASK & 8'hfb));
		end
	end

	// Pin input synchroniser
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			sync1_q <= 4'h0;
			sync2_q <= 4'h0;
		end else begin
			sync1_q <= pin_in;
			sync2_q <= sync1_q;
		end
	end

	// Digital input buffers, bits 0-2 gated by analog select, bit 3 by master clear enable
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_in
			assign din[gi] = sync2_q[gi] & ~ans_q[gi];
		end
	endgenerate
	assign din[3] = sync2_q[3] & ~master_clear_enable_cfg;

	assign master_clear_n     = master_clear_enable_cfg ? sync2_q[3] : 1'b1;
	assign capcmp3_capture_in = (route_here && dir_q[0]) ? din[0] : 1'b0;
	assign capcmp5_capture_in = dir_q[2] ? din[2] : 1'b0;

	// Output priority per pin; analog select plays no part
	always_comb begin
		out_d[0] = lat_q[0];
		if (route_here && periph.epwm3_out_a_en) begin
			out_d[0] = periph.epwm3_out_a;
		end else if (route_here && periph.capcmp3_out_en) begin
			out_d[0] = periph.capcmp3_out;
		end
		out_d[1] = periph.epwm3_out_b_en ? periph.epwm3_out_b : lat_q[1];
		out_d[2] = periph.capcmp5_out_en ? periph.capcmp5_out : lat_q[2];
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pins <= '0;
		end else begin
			pins.out <= out_d;
			pins.oe  <= ~dir_q[2:0];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			input_pin_pullup_on <= 1'b0;
		end else begin
			input_pin_pullup_on <= (master_clear_enable_cfg & ~low_volt_prog_cfg) | low_volt_prog_cfg |
				(~interrupt_control_two_q[`PEMUX_GPU_BIT] & dir_q[`PEMUX_WPU_BIT]);
		end
	end

	assign slew_reduced            = slew_q[4:0];
	assign unit3_pin_route_cfg     = cfg3h_q[`PEMUX_ROUTE_BIT];
	assign global_pullup_disable_n = interrupt_control_two_q[`PEMUX_GPU_BIT];

	// Read mux
	always_comb begin
		unique case (reg_addr)
			`PEMUX_OFF_DATA:    rdata_d = {4'h0, din};
			`PEMUX_OFF_LATCH:   rdata_d = lat_q;
			`PEMUX_OFF_DIR:     rdata_d = dir_q;
			`PEMUX_OFF_ANSEL:   rdata_d = ans_q;
			`PEMUX_OFF_INTERRUPT_CONTROL_TWO: rdata_d = interrupt_control_two_q;
			`PEMUX_OFF_SLEW:    rdata_d = slew_q;
			`PEMUX_OFF_CFG3H:   rdata_d = cfg3h_q;
			`PEMUX_OFF_CFG4L:   rdata_d = cfg4l_q;
			default:            rdata_d = 8'h00;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= reg_rd ? rdata_d : 8'h00;
		end
	end

	// Reset defaults
	a_reset_analog: assert property (
		@(posedge ref_clk)
		rst |=> ans_q[2:0] == 3'h7)
		else $error("analog select not set by reset");

	// Direction checked first, the drivers it disables one edge later
	a_reset_dir: assert property (
		@(posedge ref_clk)
		rst |=> dir_q[2:0] == 3'h7 ##1 pins.oe == 3'h0)
		else $error("direction not input after reset");

	a_reset_slew: assert property (
		@(posedge ref_clk)
		rst |=> slew_q == `PEMUX_SLEW_RST)
		else $error("slew not reduced after reset");

	// Input side
	a_analog_read_zero: assert property (
		@(posedge ref_clk) disable iff (rst)
		(din[2:0] & ans_q[2:0]) == 3'h0)
		else $error("analog pin read nonzero");

	a_unimpl_zero: assert property (
		@(posedge ref_clk) disable iff (rst)
		(lat_q & ~`PEMUX_LAT_MASK) == 8'h00 && (ans_q & ~`PEMUX_ANS_MASK) == 8'h00)
		else $error("unimplemented bit set");

	a_read_idle: assert property (
		@(posedge ref_clk) disable iff (rst)
		!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data outside read cycle");

	a_data_read: assert property (
		@(posedge ref_clk) disable iff (rst)
		reg_rd && reg_addr == `PEMUX_OFF_DATA |=> reg_rdata == {4'h0, $past(din)})
		else $error("data read not pin levels");

	a_unit3_capture: assert property (
		@(posedge ref_clk) disable iff (rst)
		!dir_q[0] |-> !capcmp3_capture_in)
		else $error("unit3 capture while driving");

	a_unit5_capture: assert property (
		@(posedge ref_clk) disable iff (rst)
		dir_q[2] |-> capcmp5_capture_in == din[2])
		else $error("unit5 capture lost");

	a_master_clear_n_input: assert property (
		@(posedge ref_clk) disable iff (rst)
		master_clear_enable_cfg |-> din[3] == 1'b0 && master_clear_n == sync2_q[3])
		else $error("master clear pin misrouted");

	a_port_input: assert property (
		@(posedge ref_clk) disable iff (rst)
		!master_clear_enable_cfg |-> din[3] == sync2_q[3] && master_clear_n)
		else $error("input-only bit misrouted");

	// Output side
	a_latch_drive: assert property (
		@(posedge ref_clk) disable iff (rst)
		!periph.epwm3_out_b_en && !dir_q[1] |=> pins.oe[1] && pins.out[1] == $past(lat_q[1]))
		else $error("latch not on pin 1");

	a_analog_drive: assert property (
		@(posedge ref_clk) disable iff (rst)
		ans_q[0] && !dir_q[0] |=> pins.oe[0])
		else $error("analog pin lost its driver");

	a_oe_follows_dir: assert property (
		@(posedge ref_clk) disable iff (rst)
		1'b1 |=> pins.oe == ~$past(dir_q[2:0]))
		else $error("drive enable not from direction");

	a_pwm_priority: assert property (
		@(posedge ref_clk) disable iff (rst)
		route_here && periph.epwm3_out_a_en |=> pins.out[0] == $past(periph.epwm3_out_a))
		else $error("pwm a lost priority");

	a_unit3_second: assert property (
		@(posedge ref_clk) disable iff (rst)
		route_here && !periph.epwm3_out_a_en && periph.capcmp3_out_en
		|=> pins.out[0] == $past(periph.capcmp3_out))
		else $error("unit3 compare lost priority");

	a_route_away: assert property (
		@(posedge ref_clk) disable iff (rst)
		!route_here |=> pins.out[0] == $past(lat_q[0]))
		else $error("routed-away source on pin 0");

	a_pwm_b_drive: assert property (
		@(posedge ref_clk) disable iff (rst)
		periph.epwm3_out_b_en |=> pins.out[1] == $past(periph.epwm3_out_b))
		else $error("pwm b not driving");

	a_unit5_drive: assert property (
		@(posedge ref_clk) disable iff (rst)
		periph.capcmp5_out_en |=> pins.out[2] == $past(periph.capcmp5_out))
		else $error("unit5 not driving");

	// Configuration and pull-up
	a_lvp_locked: assert property (
		@(posedge ref_clk) disable iff (rst)
		!hv_prog_mode |=> low_volt_prog_cfg == $past(low_volt_prog_cfg))
		else $error("lvp changed outside programming");

	a_pullup_forced: assert property (
		@(posedge ref_clk) disable iff (rst)
		low_volt_prog_cfg ##1 low_volt_prog_cfg |-> input_pin_pullup_on)
		else $error("pull-up not forced");

	a_pullup_global: assert property (
		@(posedge ref_clk) disable iff (rst)
		interrupt_control_two_q[`PEMUX_GPU_BIT] && !master_clear_enable_cfg && !low_volt_prog_cfg |=> !input_pin_pullup_on)
		else $error("pull-up on while globally disabled");

	c_pwm_out: cover property (@(posedge ref_clk) route_here && periph.epwm3_out_a_en && !dir_q[0]);
	c_analog_out: cover property (@(posedge ref_clk) ans_q[2] && !dir_q[2]);
	c_master_clear_n: cover property (@(posedge ref_clk) master_clear_enable_cfg && !sync2_q[3]);
	c_route_away: cover property (@(posedge ref_clk) !route_here && periph.capcmp3_out_en);
	c_input_only: cover property (@(posedge ref_clk) !master_clear_enable_cfg && sync2_q[3]);
endmodule
